// *** verilog/dprsem_host.sv ***
// one-port host that drives the shared ram and its semaphore latches
`timescale 1ns/1ps
module dprsem_host
  import dprsem_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [11:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_done,
  output logic [7:0] rsp_data,
  output logic rsp_grant,
  output logic [11:0] ram_addr,
  output logic mem_select_n,
  output logic latch_select_n,
  output logic rw_n,
  output logic out_drive_n,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [7:0] data_in
);
  // data pin synchroniser, first stage feeds only the second
  logic [7:0] d_s1_r;
  logic [7:0] d_s2_r;
  logic [7:0] d_s3_r;
  logic [7:0] d_clean_r;
  logic [7:0] d_clean_nxt;
  // sequencer state
  dprsem_state_t state_r, state_nxt;
  dprsem_op_t op_r, op_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] poll_r, poll_nxt;
  logic rd_phase_r, rd_phase_nxt; // readback step of an acquire
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic grant_r, grant_nxt;
  logic msel_n_r, msel_n_nxt;
  logic lsel_n_r, lsel_n_nxt;
  logic rw_n_r, rw_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic doe_n_r, doe_n_nxt;
  logic use_sem;
  logic wait_done;

  // a change counts once the last two stages agree
  always_comb begin
    d_clean_nxt = (d_s2_r == d_s3_r) ? d_s3_r : d_clean_r;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      d_s1_r <= DATA_RST;
      d_s2_r <= DATA_RST;
      d_s3_r <= DATA_RST;
      d_clean_r <= DATA_RST;
    end else begin
      d_s1_r <= data_in;
      d_s2_r <= d_s1_r;
      d_s3_r <= d_s2_r;
      d_clean_r <= d_clean_nxt;
    end
  end

  // anything but a plain memory access goes to the latches
  assign use_sem = (op_r != OP_MEM_READ) && (op_r != OP_MEM_WRITE);
  assign wait_done = (cnt_r == 4'h0);

  // next-state and pin logic
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    cnt_nxt = wait_done ? cnt_r : cnt_r - 4'h1;
    poll_nxt = poll_r;
    rd_phase_nxt = rd_phase_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    grant_nxt = grant_r;
    msel_n_nxt = msel_n_r;
    lsel_n_nxt = lsel_n_r;
    rw_n_nxt = rw_n_r;
    oe_n_nxt = oe_n_r;
    dout_nxt = dout_r;
    doe_n_nxt = doe_n_r;
    case (state_r)
      ST_IDLE: begin
        // both selects high here, the part sits powered down
        if (cmd_valid) begin
          // callers guard shared words with a latch first
          op_nxt = dprsem_op_t'(cmd_op);
          addr_nxt = cmd_addr;
          poll_nxt = 8'h00;
          rd_phase_nxt = 1'b0;
          ready_nxt = 1'b0;
          cnt_nxt = SETUP_LOAD;
          state_nxt = ST_ADDR;
          case (cmd_op)
            OP_MEM_READ: wdata_nxt = cmd_wdata;
            OP_MEM_WRITE: wdata_nxt = cmd_wdata;
            OP_SEM_ACQUIRE: wdata_nxt = SEM_REQUEST;
            OP_SEM_RELEASE: wdata_nxt = SEM_FREE;
            OP_SEM_INIT: begin
              // free every latch, from index zero upward
              wdata_nxt = SEM_FREE;
              addr_nxt = ADDR_RST;
            end
            default: begin
              // unknown op finishes at once with no pin activity
              ready_nxt = 1'b1;
              done_nxt = 1'b1;
              state_nxt = ST_IDLE;
            end
          endcase
        end
      end
      ST_ADDR: begin
        // address settles with rw high before any strobe
        if (wait_done) begin
          if (use_sem) begin
            lsel_n_nxt = 1'b0;
          end else begin
            msel_n_nxt = 1'b0;
          end
          if (op_r == OP_MEM_READ || rd_phase_r) begin
            oe_n_nxt = 1'b0;
            cnt_nxt = READ_LOAD;
            state_nxt = ST_RD_WAIT;
          end else begin
            rw_n_nxt = 1'b0;
            cnt_nxt = WR_OPEN_LOAD;
            state_nxt = ST_WR_OPEN;
          end
        end
      end
      ST_WR_OPEN: begin
        // wait for the part to let go of the data pins
        if (wait_done) begin
          doe_n_nxt = 1'b0;
          // latch writes carry only bit zero, the rest are don't-care ones
          dout_nxt = use_sem ? {7'h7f, wdata_r[0]} : wdata_r;
          cnt_nxt = WR_DATA_LOAD;
          state_nxt = ST_WR_DATA;
        end
      end
      ST_WR_DATA: begin
        // float plus setup exceeds the least pulse, so one timing serves both
        if (wait_done) begin
          rw_n_nxt = 1'b1;
          msel_n_nxt = 1'b1;
          lsel_n_nxt = 1'b1;
          cnt_nxt = HOLD_LOAD;
          state_nxt = ST_WR_END;
        end
      end
      ST_WR_END: begin
        // data and address held past the rising strobe
        if (wait_done) begin
          doe_n_nxt = 1'b1;
          if (op_r == OP_SEM_ACQUIRE) begin
            cnt_nxt = GAP_LOAD;
            state_nxt = ST_GAP;
          end else if (op_r == OP_SEM_INIT && addr_r[2:0] != LATCH_LAST) begin
            addr_nxt = {9'h000, 3'(addr_r[2:0] + 3'h1)};
            cnt_nxt = SETUP_LOAD;
            state_nxt = ST_ADDR;
          end else begin
            ready_nxt = 1'b1;
            done_nxt = 1'b1;
            grant_nxt = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        // latch select stays high long enough for the flag to update
        if (wait_done) begin
          rd_phase_nxt = 1'b1;
          cnt_nxt = SETUP_LOAD;
          state_nxt = ST_ADDR;
        end
      end
      ST_RD_WAIT: begin
        // access time plus synchroniser latency
        if (wait_done) begin
          rdata_nxt = d_clean_r;
          msel_n_nxt = 1'b1;
          lsel_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          cnt_nxt = FLOAT_LOAD;
          state_nxt = ST_RD_END;
        end
      end
      ST_RD_END: begin
        // no drive until the part has floated its outputs
        if (wait_done) begin
          if (op_r == OP_SEM_ACQUIRE) begin
            if (!rdata_r[0]) begin
              // zero means this port now owns the latch
              grant_nxt = 1'b1;
              ready_nxt = 1'b1;
              done_nxt = 1'b1;
              state_nxt = ST_IDLE;
            end else if (poll_r == POLL_LIMIT) begin
              // give up and cancel the pending request
              op_nxt = OP_SEM_RELEASE;
              wdata_nxt = SEM_FREE;
              rd_phase_nxt = 1'b0;
              cnt_nxt = SETUP_LOAD;
              state_nxt = ST_ADDR;
            end else begin
              // denied, request stays pending while we poll
              poll_nxt = poll_r + 8'h01;
              cnt_nxt = SETUP_LOAD;
              state_nxt = ST_ADDR;
            end
          end else begin
            grant_nxt = 1'b0;
            ready_nxt = 1'b1;
            done_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ready_nxt = 1'b1;
        msel_n_nxt = 1'b1;
        lsel_n_nxt = 1'b1;
        rw_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        doe_n_nxt = 1'b1;
      end
    endcase
  end

  // sequencer registers, pins park idle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      op_r <= OP_MEM_READ;
      addr_r <= ADDR_RST;
      wdata_r <= DATA_RST;
      cnt_r <= 4'h0;
      poll_r <= 8'h00;
      rd_phase_r <= 1'b0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      rdata_r <= DATA_RST;
      grant_r <= 1'b0;
      msel_n_r <= 1'b1;
      lsel_n_r <= 1'b1;
      rw_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      dout_r <= DATA_RST;
      doe_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      cnt_r <= cnt_nxt;
      poll_r <= poll_nxt;
      rd_phase_r <= rd_phase_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      grant_r <= grant_nxt;
      msel_n_r <= msel_n_nxt;
      lsel_n_r <= lsel_n_nxt;
      rw_n_r <= rw_n_nxt;
      oe_n_r <= oe_n_nxt;
      dout_r <= dout_nxt;
      doe_n_r <= doe_n_nxt;
    end
  end

  assign cmd_ready = ready_r;
  assign rsp_done = done_r;
  assign rsp_data = rdata_r;
  assign rsp_grant = grant_r;
  assign ram_addr = addr_r;
  assign mem_select_n = msel_n_r;
  assign latch_select_n = lsel_n_r;
  assign rw_n = rw_n_r;
  assign out_drive_n = oe_n_r;
  assign data_out = dout_r;
  assign data_oe_n = doe_n_r;

  // pin protocol checks
  property p_wr_start;
    @(posedge clock) disable iff (!arst_n) $fell(rw_n_r) |-> (!msel_n_r || !lsel_n_r);
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write began without a select low");
  property p_addr_rw;
    @(posedge clock) disable iff (!arst_n) $changed(addr_r) |-> rw_n_r && $past(rw_n_r);
  endproperty
  a_addr_rw: assert property (p_addr_rw) else $error("address moved with rw low");
  property p_no_fight;
    @(posedge clock) disable iff (!arst_n) !doe_n_r |-> oe_n_r;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("data driven with output drive low");
  property p_float_first;
    @(posedge clock) disable iff (!arst_n) $fell(doe_n_r) |-> !$past(rw_n_r, 3);
  endproperty
  a_float_first: assert property (p_float_first) else $error("data driven before the float delay");
  property p_pulse;
    @(posedge clock) disable iff (!arst_n) $rose(rw_n_r) |-> !$past(rw_n_r, 6) && !$past(doe_n_r, 3);
  endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse or data setup too short");
  property p_hold;
    @(posedge clock) disable iff (!arst_n) $rose(rw_n_r) |-> !doe_n_r;
  endproperty
  a_hold: assert property (p_hold) else $error("data not held past write end");
  property p_one_select;
    @(posedge clock) disable iff (!arst_n) !(!msel_n_r && !lsel_n_r);
  endproperty
  a_one_select: assert property (p_one_select) else $error("both selects low");
  property p_read;
    @(posedge clock) disable iff (!arst_n) !oe_n_r |-> rw_n_r && (!msel_n_r || !lsel_n_r);
  endproperty
  a_read: assert property (p_read) else $error("output drive without a read select");
  property p_sem_gap;
    // init rewrites the next latch at once, so only a read must keep away
    @(posedge clock) disable iff (!arst_n) $rose(lsel_n_r) && !$past(rw_n_r) |-> oe_n_r [*3];
  endproperty
  a_sem_gap: assert property (p_sem_gap) else $error("latch reread too soon after write");
  property p_bit0;
    @(posedge clock) disable iff (!arst_n) !doe_n_r && !lsel_n_r |-> dout_r[7:1] == 7'h7f;
  endproperty
  a_bit0: assert property (p_bit0) else $error("latch write upper lines not parked");
  property p_idle_down;
    @(posedge clock) disable iff (!arst_n) ready_r |-> msel_n_r && lsel_n_r && doe_n_r;
  endproperty
  a_idle_down: assert property (p_idle_down) else $error("selects or drive active while idle");
endmodule

// *** verilog/dprsem_pkg.sv ***
// constants and types for the dual-port ram semaphore port host
package dprsem_pkg;
  localparam int CLK_PERIOD_NS = 5; // 200 mhz
  // pin timings of the attached part, ns
  localparam int SELECT_ACCESS_TIME_NS = 25;
  localparam int OUTPUT_ACCESS_TIME_NS = 15;
  localparam int OUTPUT_FLOAT_DELAY_NS = 15;
  localparam int WRITE_FLOAT_DELAY_NS = 15;
  localparam int DATA_SETUP_TIME_NS = 15;
  localparam int WRITE_PULSE_MIN_NS = 20;
  localparam int FLAG_UPDATE_PULSE_NS = 10;
  localparam int FLAG_WRITE_READ_TIME_NS = 5;
  localparam int ADDR_HOLD_NS = 2;
  // least times round up to whole cycles
  localparam int SELECT_ACCESS_CYC = (SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUTPUT_ACCESS_CYC = (OUTPUT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUTPUT_FLOAT_CYC = (OUTPUT_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_FLOAT_CYC = (WRITE_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_CYC = (DATA_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_UPDATE_CYC = (FLAG_UPDATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_WR_RD_CYC = (FLAG_WRITE_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // the sampling edge after access, three stages, then the agreement register
  // a shorter count hands back the stale byte that stood before the access
  localparam int SYNC_CYC = 5;
  localparam int ADDR_SETUP_CYC = 1;
  // derived phase lengths
  localparam int READ_CYC = ((SELECT_ACCESS_CYC > OUTPUT_ACCESS_CYC) ? SELECT_ACCESS_CYC : OUTPUT_ACCESS_CYC)
                            + SYNC_CYC;
  localparam int WR_DATA_CYC = (DATA_SETUP_CYC > WRITE_PULSE_CYC - WRITE_FLOAT_CYC) ? DATA_SETUP_CYC
                               : WRITE_PULSE_CYC - WRITE_FLOAT_CYC;
  localparam int SEM_GAP_CYC = (FLAG_UPDATE_CYC > FLAG_WR_RD_CYC) ? FLAG_UPDATE_CYC : FLAG_WR_RD_CYC;
  // counter loads, counter runs down to zero
  localparam logic [3:0] READ_LOAD = 4'(READ_CYC - 1);
  localparam logic [3:0] WR_OPEN_LOAD = 4'(WRITE_FLOAT_CYC - 1);
  localparam logic [3:0] WR_DATA_LOAD = 4'(WR_DATA_CYC - 1);
  localparam logic [3:0] FLOAT_LOAD = 4'(OUTPUT_FLOAT_CYC - 1);
  localparam logic [3:0] GAP_LOAD = 4'(SEM_GAP_CYC - 1);
  localparam logic [3:0] HOLD_LOAD = 4'(ADDR_HOLD_CYC - 1);
  localparam logic [3:0] SETUP_LOAD = 4'(ADDR_SETUP_CYC - 1);
  // field layout and reset values
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LATCH_INDEX_W = 3; // eight latches
  localparam logic [2:0] LATCH_LAST = 3'h7;
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] SEM_REQUEST = 8'hfe; // bit 0 low, the rest are ignored
  localparam logic [7:0] SEM_FREE = 8'hff;
  localparam logic [7:0] POLL_LIMIT = 8'h40;
  typedef enum logic [2:0] {
    OP_MEM_READ = 3'h0,
    OP_MEM_WRITE = 3'h1,
    OP_SEM_ACQUIRE = 3'h2,
    OP_SEM_RELEASE = 3'h3,
    OP_SEM_INIT = 3'h4
  } dprsem_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WR_OPEN = 3'b011,
    ST_WR_DATA = 3'b010,
    ST_WR_END = 3'b110,
    ST_RD_WAIT = 3'b111,
    ST_RD_END = 3'b101,
    ST_GAP = 3'b100
  } dprsem_state_t;
endpackage

// *** test/dprsem_ram_model.sv ***
// behavioural shared ram with eight latches; left port on pins, right port by task
`timescale 1ns/1ps
module dprsem_ram_model
  import dprsem_pkg::*;
(
  input wire logic [11:0] addr,
  input wire logic mem_select_n,
  input wire logic latch_select_n,
  input wire logic rw_n,
  input wire logic out_drive_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_q,
  output logic drive
);
  logic [7:0] mem [0:4095]; // shared array
  logic [1:0] own [0:7]; // 0 free, 1 left, 2 right
  logic [1:0] pend [0:7]; // bit 0 left waits, bit 1 right waits
  logic [7:0] sem_q; // latch read register
  logic ready_q; // access time has run out
  logic [7:0] val; // what a read shows
  wire mem_wr = !mem_select_n && latch_select_n && !rw_n;
  wire sem_wr = !latch_select_n && mem_select_n && !rw_n;
  wire rd = !out_drive_n && rw_n && (mem_select_n != latch_select_n);
  assign drive = rd;
  assign val = latch_select_n ? mem[addr] : sem_q;
  // released pins show the inverse, so a stale sample never matches
  assign data_q = (rd && ready_q) ? val : ~val;
  // one latch update; serial calls grant exactly one of two racing requests
  task automatic sem_write(input int p, input logic [2:0] i, input logic b);
    int o;
    o = 3 - p;
    if (!b) begin
      if (own[i] == 2'd0) own[i] = 2'(p);
      else if (own[i] != 2'(p)) pend[i][p-1] = 1'b1;
    end else begin
      pend[i][p-1] = 1'b0;
      if (own[i] == 2'(p)) begin
        own[i] = pend[i][o-1] ? 2'(o) : 2'd0;
        pend[i][o-1] = 1'b0;
      end
    end
  endtask
  // right host: optional write, then read back on all lines
  task automatic right_sem(input logic wr, input logic [2:0] i, input logic b, output logic [7:0] q);
    if (wr) sem_write(2, i, b);
    q = {8{own[i] != 2'd2}};
  endtask
  task automatic right_mem_write(input logic [11:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
  // write lands when select or rw ends it; time zero guard skips x to 0
  always @(negedge mem_wr) if ($time > 0) mem[addr] = data_in;
  always @(negedge sem_wr) if ($time > 0) sem_write(1, addr[2:0], data_in[0]);
  // latch value frozen at read start
  always @(posedge rd) begin
    sem_q = {8{own[addr[2:0]] != 2'd1}};
    ready_q = 1'b0;
    #(SELECT_ACCESS_TIME_NS);
    ready_q = rd;
  end
  always @(negedge rd) ready_q = 1'b0;
  // latches wake up owned by the right side, not free
  initial begin
    ready_q = 1'b0;
    sem_q = 8'h00;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    for (int i = 0; i < 8; i++) begin
      own[i] = 2'd2;
      pend[i] = 2'd0;
    end
  end
endmodule

// *** test/testbench.sv ***
// self-checking bench for the port host against the ram model
`timescale 1ns/1ps
module testbench
  import dprsem_pkg::*;
;
  logic clock, arst_n, cmd_valid;
  logic [2:0] cmd_op;
  logic [11:0] cmd_addr, ram_addr;
  logic [7:0] cmd_wdata, rsp_data, data_out, data_q, q;
  logic cmd_ready, rsp_done, rsp_grant, mem_select_n, latch_select_n, rw_n, out_drive_n, data_oe_n, drive;
  wire [7:0] data_in = !data_oe_n ? data_out : data_q; // host wins only when it drives
  int fail_count, n_compared, lat;
  logic pins_used; // any select seen during a command
  dprsem_host dut (.clock(clock), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_done(rsp_done),
    .rsp_data(rsp_data), .rsp_grant(rsp_grant), .ram_addr(ram_addr), .mem_select_n(mem_select_n),
    .latch_select_n(latch_select_n), .rw_n(rw_n), .out_drive_n(out_drive_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(data_in));
  dprsem_ram_model u_ram (.addr(ram_addr), .mem_select_n(mem_select_n), .latch_select_n(latch_select_n),
    .rw_n(rw_n), .out_drive_n(out_drive_n), .data_in(data_in), .data_q(data_q), .drive(drive));
  always #2.5 clock = ~clock;
  // byte compare
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // count compare
  task automatic chk_n(input string what, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // issue at this edge, taken next edge; lat counts edges to the sampled done
  task automatic run(input logic [2:0] op, input logic [11:0] a, input logic [7:0] d);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    lat = 0;
    pins_used = 1'b0;
    do begin
      @(posedge clock);
      lat++;
      if (!mem_select_n || !latch_select_n) pins_used = 1'b1;
    end while (rsp_done !== 1'b1 && lat < 2000);
  endtask
  // both drivers on the data pins at once
  always @(posedge clock) if (arst_n && !data_oe_n && drive) chk8("bus contention", 8'h00, 8'h01);
  task automatic t_reset;
    chk8("idle pins", 8'h3f, {2'h0, cmd_ready, data_oe_n, mem_select_n, latch_select_n, rw_n, out_drive_n});
    chk8("grant at reset", 8'h00, {7'h00, rsp_grant});
  endtask
  // init, then right side frees too; take latch 1 with high address bits set
  task automatic t_init;
    run(3'h4, 12'h000, 8'h00);
    chk_n("init latency", 65, lat);
    for (int i = 0; i < 8; i++) u_ram.right_sem(1'b1, 3'(i), 1'b1, q);
    run(3'h2, 12'hff9, 8'h00);
    chk_n("acquire latency", 25, lat);
    chk8("grant", 8'h01, {7'h00, rsp_grant});
    chk8("owner readback", 8'h00, rsp_data);
    u_ram.right_sem(1'b0, 3'h1, 1'b0, q);
    chk8("other side sees", 8'hff, q);
    u_ram.right_sem(1'b1, 3'h1, 1'b0, q);
    chk8("denied request", 8'hff, q);
    run(3'h3, 12'h001, 8'h00);
    chk_n("release latency", 9, lat);
    u_ram.right_sem(1'b0, 3'h1, 1'b0, q);
    chk8("pending passes", 8'h00, q);
    u_ram.right_sem(1'b1, 3'h1, 1'b1, q);
  endtask
  // back-to-back write and read, then data written by the far port
  task automatic t_mem;
    run(3'h1, 12'hfff, 8'ha5);
    chk_n("write latency", 9, lat);
    run(3'h0, 12'hfff, 8'h00);
    chk_n("read latency", 15, lat);
    chk8("read data", 8'ha5, rsp_data);
    u_ram.right_mem_write(12'h001, 8'h3c);
    run(3'h0, 12'h001, 8'h00);
    chk8("far port data", 8'h3c, rsp_data);
  endtask
  // owned latch: polling until the right side lets go
  task automatic t_poll;
    u_ram.right_sem(1'b1, 3'h3, 1'b0, q);
    fork
      run(3'h2, 12'h003, 8'h00);
      begin
        repeat (100) @(posedge clock);
        u_ram.right_sem(1'b1, 3'h3, 1'b1, q);
      end
    join
    chk_n("poll spacing", 0, (lat - 25) % 14);
    chk8("grant after wait", 8'h01, {7'h00, rsp_grant});
    u_ram.right_sem(1'b0, 3'h3, 1'b0, q);
    chk8("right lost latch", 8'hff, q);
    run(3'h3, 12'h003, 8'h00);
    // a free latch goes to the right side at its first request
    u_ram.right_sem(1'b1, 3'h3, 1'b0, q);
    chk8("latch free", 8'h00, q);
    u_ram.right_sem(1'b1, 3'h3, 1'b1, q);
  endtask
  // never granted: cancel must drop the pending request
  task automatic t_cancel;
    u_ram.right_sem(1'b1, 3'h5, 1'b0, q);
    run(3'h2, 12'h005, 8'h00);
    chk_n("cancel latency", 929, lat);
    chk8("no grant", 8'h00, {7'h00, rsp_grant});
    u_ram.right_sem(1'b1, 3'h5, 1'b1, q);
    u_ram.right_sem(1'b1, 3'h5, 1'b0, q);
    chk8("request dropped", 8'h00, q);
    u_ram.right_sem(1'b1, 3'h5, 1'b1, q);
    run(3'h7, 12'h000, 8'h00);
    chk_n("bad op latency", 1, lat);
    chk8("bad op pins", 8'h00, {7'h00, pins_used});
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // cut a hang well past the expected twelve hundred cycles
  initial begin
    #100000;
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_addr = 12'h000;
    cmd_wdata = 8'h00;
    fail_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clock);
    t_reset();
    arst_n <= 1'b1;
    t_init();
    t_mem();
    t_poll();
    t_cancel();
    finish_test();
  end
endmodule
